//--- rtl/sxd_defines.svh
// Named constants for the extended command decoder: characters, codes, reset values.
// Assumes 8-bit ASCII characters on the serial side and one 10 MHz clock.
`ifndef SXD_DEFINES_SVH
`define SXD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Command and reply characters
// ----------------------------------------------------------------------------
`define SXD_CH_BANG      8'h21
`define SXD_CH_QUERY     8'h3F
`define SXD_CH_X         8'h58
`define SXD_CH_A         8'h41
`define SXD_CH_D         8'h44
`define SXD_CH_I         8'h49
`define SXD_CH_E         8'h45
`define SXD_CH_S         8'h53
`define SXD_CH_PLUS      8'h2B
`define SXD_CH_MINUS     8'h2D
`define SXD_CH_DOT       8'h2E
`define SXD_CH_0         8'h30
`define SXD_CH_1         8'h31
`define SXD_CH_2         8'h32
`define SXD_CH_3         8'h33
`define SXD_CH_9         8'h39
`define SXD_CH_CR        8'h0D
`define SXD_CH_LF        8'h0A
`define SXD_CH_NUL       8'h00
`define SXD_CH_ADDR_SLOT 8'h40

// ----------------------------------------------------------------------------
// Reset values, unit codes and value scaling
// ----------------------------------------------------------------------------
`define SXD_RST_ADDR     8'h30
`define SXD_UNIT_PSI     4'h1
`define SXD_SEP_FEET     3'h0
`define SXD_SEP_MAX      4'h4
`define SXD_FRAC_MAX     2'h2
`define SXD_LINE_ONE     1'b0
`define SXD_LINE_TWO     1'b1
`define SXD_VAL_ZERO     24'h000000

// ----------------------------------------------------------------------------
// Reply text layout: identity field positions inside the identity reply
// ----------------------------------------------------------------------------
`define SXD_ID_VENDOR_POS 5'h03
`define SXD_ID_MODEL_POS  5'h0B
`define SXD_ID_HW_POS     5'h11
`define SXD_ID_CR_POS     5'h14

`endif

//--- rtl/sxd_pkg.sv
// Types shared by the extended command decoder and its reply text memory.
// Assumes sxd_defines.svh is compiled alongside; no constants live here.
package sxd_pkg;

	// ------------------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		SXD_TXT_ADDR, SXD_TXT_ACK, SXD_TXT_IDENT, SXD_TXT_TIMED
	} sxd_text_e;

	typedef enum logic [2:0] {
		SXD_OP_NONE, SXD_OP_QUERY, SXD_OP_ADDR, SXD_OP_IDENT, SXD_OP_CAL, SXD_OP_LEVEL
	} sxd_op_e;

	typedef enum logic [3:0] {
		SXD_ST_IDLE, SXD_ST_X, SXD_ST_OP, SXD_ST_A, SXD_ST_NEWA1, SXD_ST_NEWA2,
		SXD_ST_END, SXD_ST_SEL, SXD_ST_VAL, SXD_ST_UNIT, SXD_ST_SKIP, SXD_ST_EXEC,
		SXD_ST_FETCH, SXD_ST_LOAD, SXD_ST_SEND
	} sxd_state_e;

	// ------------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------------
	typedef logic signed [23:0] sxd_val_t;

	typedef struct packed {
		logic       dual_variant;
		logic       dual_expanded;
		logic       density_mode;
		logic       active_line;
		logic [3:0] level_units;
	} sxd_cfg_s;

	typedef struct packed {
		sxd_val_t [1:0]   offset;
		logic [1:0][3:0]  offset_unit;
		sxd_val_t         separation;
		logic [2:0]       separation_unit;
		sxd_val_t         density;
	} sxd_cal_s;

	typedef struct packed {
		sxd_state_e st;
		sxd_op_e    op;
		sxd_text_e  kind;
		logic [4:0] idx;
		logic [7:0] addr;
		logic       wild;
		logic [7:0] new_a1;
		logic [7:0] new_a2;
		logic       sel_given;
		logic       sel;
		logic       val_given;
		logic       neg;
		logic       in_frac;
		logic [1:0] frac;
		sxd_val_t   acc;
		logic       unit_given;
		logic [3:0] unit;
		logic [7:0] tx_char;
		logic       tx_valid;
		logic       done;
		sxd_cal_s   cal;
	} sxd_dec_s;

endpackage : sxd_pkg

//--- rtl/sxd_text_rom.sv
// Reply text memory: one template per reply kind, NUL-terminated, read through a register.
// Assumes the caller replaces the address slot character with the live bus address.
`include "sxd_defines.svh"

module sxd_text_rom #(
	parameter logic [63:0] VENDOR = "ACMEINST", // Arbitrary neutral vendor field.
	parameter logic [47:0] MODEL  = "LVL100",   // Arbitrary neutral model field.
	parameter logic [23:0] HW_VER = "001"       // Arbitrary neutral hardware version.
) (
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire sxd_pkg::sxd_text_e kind,
	input  wire logic [4:0]        idx,
	output logic [7:0]             rd_data
);

	typedef struct packed {
		logic [7:0] data;
	} sxd_rom_s;

	sxd_rom_s q;
	sxd_rom_s d;
	logic [4:0] rel;

	// ------------------------------------------------------------------------
	// Template lookup
	// ------------------------------------------------------------------------
	// Fields are picked by offset from their end so the strings stay parameters.
	always_comb begin
		d = q;
		d.data = `SXD_CH_NUL;
		rel = 5'h00;
		if (idx == 5'h00) begin
			d.data = `SXD_CH_ADDR_SLOT;
		end else begin
			case (kind)
				sxd_pkg::SXD_TXT_ADDR: begin
					if (idx == 5'h01) d.data = `SXD_CH_CR;
					else if (idx == 5'h02) d.data = `SXD_CH_LF;
				end
				sxd_pkg::SXD_TXT_ACK, sxd_pkg::SXD_TXT_TIMED: begin
					// Completion code, or zero seconds plus one value to collect.
					if (idx <= 5'h03) begin
						d.data = (kind == sxd_pkg::SXD_TXT_ACK && idx == 5'h03) ?
							`SXD_CH_1 : `SXD_CH_0;
					end else if (idx == 5'h04) d.data = `SXD_CH_1;
					else if (idx == 5'h05) d.data = `SXD_CH_CR;
					else if (idx == 5'h06) d.data = `SXD_CH_LF;
				end
				sxd_pkg::SXD_TXT_IDENT: begin
					if (idx == 5'h01) begin
						d.data = `SXD_CH_1;
					end else if (idx == 5'h02) begin
						d.data = `SXD_CH_3;
					end else if (idx < `SXD_ID_MODEL_POS) begin
						rel = 5'(`SXD_ID_MODEL_POS - idx - 5'h01);
						d.data = VENDOR[rel*8 +: 8];
					end else if (idx < `SXD_ID_HW_POS) begin
						rel = 5'(`SXD_ID_HW_POS - idx - 5'h01);
						d.data = MODEL[rel*8 +: 8];
					end else if (idx < `SXD_ID_CR_POS) begin
						rel = 5'(`SXD_ID_CR_POS - idx - 5'h01);
						d.data = HW_VER[rel*8 +: 8];
					end else if (idx == `SXD_ID_CR_POS) begin
						d.data = `SXD_CH_CR;
					end else if (idx == 5'(`SXD_ID_CR_POS + 5'h01)) begin
						d.data = `SXD_CH_LF;
					end
				end
				default: d.data = `SXD_CH_NUL;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Read register
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) q <= '{data: `SXD_CH_NUL};
		else q <= d;
	end

	assign rd_data = q.data;

endmodule : sxd_text_rom

//--- rtl/sxd_decoder.sv
// Extended command decoder and responder for a bubbler level sensor on an SDI-12 bus.
// Assumes a character receiver and transmitter on the same clock handle the line itself.
// What this block does
// [R1] Wildcard query answers with own current address, whatever address it was sent to.
// [R2] Address change carries new address twice; accepted change acknowledged with completion code.
// [R3] Differing address copies: send nothing, keep existing address.
// [R4] Identity reply: address, protocol version, vendor, model, hardware version.
// [R5] Calibration selector 1 means line one, 2 means line two or density.
// [R6] Dual expanded, no selector: calibration applies to currently active line.
// [R7] Density setup: value is orifice separation, unit 0 ft..4 mm.
// [R8] Parameters optional; no selector outside dual expanded acts on line one.
// [R9] Absent value leaves stored calibration offset unchanged.
// [R10] Absent unit on calibration command means pounds per square inch.
// [R11] Calibration and set-level reply address, three-digit seconds, one value.
// [R12] Later data request shows new offset in current level units.
// [R13] Set-level takes optional selector, level value and unit code.
// [R14] Set-level recomputes offset so current reading equals requested level.
// [R15] Density setup: set-level sets density in g/ml, ignoring unit.
// [R16] Commands start with address, end with '!', ignored on address mismatch except the query.
`include "sxd_defines.svh"

module sxd_decoder (
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic [7:0]       rx_char,
	input  wire logic             rx_valid,
	input  wire logic             tx_ready,
	input  wire sxd_pkg::sxd_cfg_s cfg,
	input  wire sxd_pkg::sxd_val_t reading_one,
	input  wire sxd_pkg::sxd_val_t reading_two,
	output logic [7:0]            tx_char,
	output logic                  tx_valid,
	output logic [7:0]            bus_addr,
	output sxd_pkg::sxd_cal_s     cal,
	output logic                  cmd_done,
	output logic                  busy
);

	sxd_pkg::sxd_dec_s q;
	sxd_pkg::sxd_dec_s d;
	logic [7:0]        rom_data;
	logic              is_digit;
	logic [3:0]        digit;
	logic              line;
	logic              density_line;
	sxd_pkg::sxd_val_t value;
	sxd_pkg::sxd_val_t reading;

	// ------------------------------------------------------------------------
	// Reply text memory
	// ------------------------------------------------------------------------
	sxd_text_rom u_text (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.kind    (q.kind),
		.idx     (q.idx),
		.rd_data (rom_data)
	);

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// Scales the collected digits to hundredths; extra fraction digits are dropped.
	function automatic sxd_pkg::sxd_val_t scale(input sxd_pkg::sxd_val_t acc,
	                                           input logic [1:0] frac, input logic neg);
		sxd_pkg::sxd_val_t v;
		v = acc;
		if (frac == 2'h0) v = 24'((acc <<< 6) + (acc <<< 5) + (acc <<< 2));
		else if (frac == 2'h1) v = 24'((acc <<< 3) + (acc <<< 1));
		scale = neg ? 24'(-v) : v;
	endfunction : scale

	// Digit test and digit value of the character now on the receive side.
	assign is_digit = (rx_char >= `SXD_CH_0) && (rx_char <= `SXD_CH_9);
	assign digit    = 4'(rx_char - `SXD_CH_0);

	// Line choice for both setting commands.
	always_comb begin
		if (!cfg.dual_variant) line = `SXD_LINE_ONE;          // [R5]
		else if (q.sel_given) line = q.sel;                    // [R5] [R13]
		else if (cfg.dual_expanded) line = cfg.active_line;    // [R6]
		else line = `SXD_LINE_ONE;                             // [R8]
	end

	assign density_line = cfg.dual_variant && cfg.density_mode && (line == `SXD_LINE_TWO);
	assign value   = scale(q.acc, q.frac, q.neg);
	assign reading = (line == `SXD_LINE_TWO) ? reading_two : reading_one;

	// ------------------------------------------------------------------------
	// Command parser, executor and reply sender
	// ------------------------------------------------------------------------
	// While a reply is being sent incoming characters are ignored; the bus is half duplex.
	always_comb begin
		d = q;
		d.done = 1'b0;
		case (q.st)
			sxd_pkg::SXD_ST_IDLE: if (rx_valid) begin
				d.wild       = (rx_char != q.addr);
				d.op         = sxd_pkg::SXD_OP_NONE;
				d.sel_given  = 1'b0;
				d.val_given  = 1'b0;
				d.unit_given = 1'b0;
				d.neg        = 1'b0;
				d.in_frac    = 1'b0;
				d.frac       = 2'h0;
				d.acc        = `SXD_VAL_ZERO;
				// Any address may carry the query, so even a foreign one walks on.
				if (rx_char != `SXD_CH_BANG) d.st = sxd_pkg::SXD_ST_X;            // [R1]
			end
			// After the address only the extended letter is of interest here.
			sxd_pkg::SXD_ST_X: if (rx_valid) begin
				d.st = (rx_char == `SXD_CH_X) ? sxd_pkg::SXD_ST_OP : sxd_pkg::SXD_ST_SKIP;
			end
			// Command letter; anything unknown is skipped up to the closing mark.
			// A foreign address leaves only the query open.
			sxd_pkg::SXD_ST_OP: if (rx_valid) begin
				d.st = sxd_pkg::SXD_ST_SKIP;
				if (rx_char == `SXD_CH_QUERY) begin
					d.op = sxd_pkg::SXD_OP_QUERY;                           // [R1]
					d.st = sxd_pkg::SXD_ST_END;
				end else if (!q.wild) begin                                 // [R16]
					// The wildcard only ever addresses the query.
					if (rx_char == `SXD_CH_A) begin
						d.st = sxd_pkg::SXD_ST_A;
					end else if (rx_char == `SXD_CH_E) begin
						d.op = sxd_pkg::SXD_OP_CAL;
						d.st = sxd_pkg::SXD_ST_SEL;
					end else if (rx_char == `SXD_CH_S) begin
						d.op = sxd_pkg::SXD_OP_LEVEL;                       // [R13]
						d.st = sxd_pkg::SXD_ST_SEL;
					end
				end
			end
			// Second letter of the address-change and identity commands.
			sxd_pkg::SXD_ST_A: if (rx_valid) begin
				d.st = sxd_pkg::SXD_ST_SKIP;
				if (rx_char == `SXD_CH_D) begin
					d.op = sxd_pkg::SXD_OP_ADDR;
					d.st = sxd_pkg::SXD_ST_NEWA1;
				end else if (rx_char == `SXD_CH_I) begin
					d.op = sxd_pkg::SXD_OP_IDENT;
					d.st = sxd_pkg::SXD_ST_END;
				end
			end
			// The two copies are kept apart and compared only at execution.
			sxd_pkg::SXD_ST_NEWA1: if (rx_valid) begin
				d.new_a1 = rx_char;
				d.st = (rx_char == `SXD_CH_BANG) ? sxd_pkg::SXD_ST_IDLE : sxd_pkg::SXD_ST_NEWA2;
			end
			// A closing mark here means the second copy is missing.
			sxd_pkg::SXD_ST_NEWA2: if (rx_valid) begin
				d.new_a2 = rx_char;
				d.st = (rx_char == `SXD_CH_BANG) ? sxd_pkg::SXD_ST_IDLE : sxd_pkg::SXD_ST_END;
			end
			// Only the closing mark, or a '2' after the identity command, is allowed now.
			sxd_pkg::SXD_ST_END: if (rx_valid) begin
				// The second identity form differs only by a trailing '2'.
				if (rx_char == `SXD_CH_BANG) d.st = sxd_pkg::SXD_ST_EXEC;          // [R16]
				else if (!(q.op == sxd_pkg::SXD_OP_IDENT && rx_char == `SXD_CH_2))
					d.st = sxd_pkg::SXD_ST_SKIP;
			end
			// Optional line selector, then an optional signed value.
			sxd_pkg::SXD_ST_SEL: if (rx_valid) begin
				if (rx_char == `SXD_CH_BANG) begin
					d.st = sxd_pkg::SXD_ST_EXEC;
				end else if (!q.sel_given && (rx_char == `SXD_CH_1 || rx_char == `SXD_CH_2)) begin
					d.sel_given = 1'b1;                                         // [R5]
					d.sel = (rx_char == `SXD_CH_2);
				end else if (rx_char == `SXD_CH_PLUS || rx_char == `SXD_CH_MINUS) begin
					d.neg = (rx_char == `SXD_CH_MINUS);
					d.st  = sxd_pkg::SXD_ST_VAL;
				end else begin
					d.st = sxd_pkg::SXD_ST_SKIP;
				end
			end
			// Digits of the value; fraction digits past the second are dropped,
			// which truncates rather than rounds, matching the hundredths storage.
			sxd_pkg::SXD_ST_VAL: if (rx_valid) begin
				if (rx_char == `SXD_CH_BANG) begin
					d.st = sxd_pkg::SXD_ST_EXEC;
				end else if (is_digit) begin
					d.val_given = 1'b1;
					if (!q.in_frac || q.frac != `SXD_FRAC_MAX) begin
						d.acc = 24'((q.acc <<< 3) + (q.acc <<< 1) + 24'(digit));
						if (q.in_frac) d.frac = 2'(q.frac + 2'h1);
					end
				end else if (rx_char == `SXD_CH_DOT && !q.in_frac) begin
					d.in_frac = 1'b1;
				end else if (rx_char == `SXD_CH_PLUS) begin
					d.st = sxd_pkg::SXD_ST_UNIT;
				end else begin
					d.st = sxd_pkg::SXD_ST_SKIP;
				end
			end
			// One optional unit digit; a second digit makes the frame malformed.
			sxd_pkg::SXD_ST_UNIT: if (rx_valid) begin
				if (rx_char == `SXD_CH_BANG) begin
					d.st = sxd_pkg::SXD_ST_EXEC;
				end else if (is_digit && !q.unit_given) begin
					d.unit_given = 1'b1;
					d.unit = digit;
				end else begin
					d.st = sxd_pkg::SXD_ST_SKIP;
				end
			end
			// A malformed or foreign frame is swallowed up to its closing mark,
			// since a reply would collide with the sensor really addressed.
			sxd_pkg::SXD_ST_SKIP: if (rx_valid && rx_char == `SXD_CH_BANG) begin
				d.st = sxd_pkg::SXD_ST_IDLE;                                  // [R16]
			end
			// Execution takes one cycle and pulses completion even when nothing is sent.
			// Unequal address copies go straight back to idle, silently.
			sxd_pkg::SXD_ST_EXEC: begin
				d.done = 1'b1;
				d.idx  = 5'h00;
				d.st   = sxd_pkg::SXD_ST_FETCH;
				case (q.op)
					sxd_pkg::SXD_OP_QUERY: d.kind = sxd_pkg::SXD_TXT_ADDR;         // [R1]
					sxd_pkg::SXD_OP_IDENT: d.kind = sxd_pkg::SXD_TXT_IDENT;        // [R4]
					// The new address takes effect before the acknowledgement goes out.
					sxd_pkg::SXD_OP_ADDR: begin
						if (q.new_a1 == q.new_a2) begin
							d.addr = q.new_a1;                                   // [R2]
							d.kind = sxd_pkg::SXD_TXT_ACK;                       // [R2]
						end else begin
							d.st = sxd_pkg::SXD_ST_IDLE;                         // [R3]
						end
					end
					// Density setups store separation, otherwise the chosen line's offset.
					sxd_pkg::SXD_OP_CAL: begin
						d.kind = sxd_pkg::SXD_TXT_TIMED;                           // [R11]
						if (density_line) begin
							if (q.val_given) begin
								d.cal.separation = value;                          // [R7]
								d.cal.separation_unit = (q.unit_given && q.unit <= `SXD_SEP_MAX) ?
									3'(q.unit) : `SXD_SEP_FEET;                    // [R7]
							end
						end else if (q.val_given) begin                            // [R9]
							d.cal.offset[line] = value;
							d.cal.offset_unit[line] = q.unit_given ? q.unit : `SXD_UNIT_PSI; // [R10]
						end
					end
					// Density setups store density, otherwise the offset is recomputed.
					sxd_pkg::SXD_OP_LEVEL: begin
						d.kind = sxd_pkg::SXD_TXT_TIMED;                           // [R11]
						if (density_line) begin
							if (q.val_given) d.cal.density = value;                // [R15]
						end else if (q.val_given) begin
							// Reading and level are both taken in the selected level units.
							d.cal.offset[line] = 24'(q.cal.offset[line] + value - reading); // [R14]
							d.cal.offset_unit[line] = cfg.level_units;             // [R12]
						end
					end
					default: d.st = sxd_pkg::SXD_ST_IDLE;
				endcase
			end
			// One cycle for the text memory to register the next character.
			sxd_pkg::SXD_ST_FETCH: d.st = sxd_pkg::SXD_ST_LOAD;
			sxd_pkg::SXD_ST_LOAD: begin
				// The address slot is filled live so a changed address shows at once.
				if (rom_data == `SXD_CH_NUL) begin
					d.st = sxd_pkg::SXD_ST_IDLE;
				end else begin
					d.tx_char  = (rom_data == `SXD_CH_ADDR_SLOT) ? q.addr : rom_data;
					d.tx_valid = 1'b1;
					d.st       = sxd_pkg::SXD_ST_SEND;
				end
			end
			// Hold the character until the transmitter takes it, then step on.
			// Three cycles a character is far below the serial line's own rate.
			sxd_pkg::SXD_ST_SEND: if (tx_ready) begin
				d.tx_valid = 1'b0;
				d.idx      = 5'(q.idx + 5'h01);
				d.st       = sxd_pkg::SXD_ST_FETCH;
			end
			default: d.st = sxd_pkg::SXD_ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			// Clear everything, then lay in the few fields whose idle value is not zero.
			q <= '0;
			q.st <= sxd_pkg::SXD_ST_IDLE;
			q.addr <= `SXD_RST_ADDR;
			q.cal.offset_unit <= {`SXD_UNIT_PSI, `SXD_UNIT_PSI};
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign tx_char  = q.tx_char;
	assign tx_valid = q.tx_valid;
	assign bus_addr = q.addr;
	assign cal      = q.cal;
	assign cmd_done = q.done;
	// Busy spans execution and the whole reply; received characters are dropped then.
	assign busy     = (q.st == sxd_pkg::SXD_ST_EXEC) || (q.st == sxd_pkg::SXD_ST_FETCH) ||
	                  (q.st == sxd_pkg::SXD_ST_LOAD) || (q.st == sxd_pkg::SXD_ST_SEND);

endmodule : sxd_decoder

//--- bench/sxd_decoder_assertions.sv
// Concurrent checks on the decoder's ports, bound to every decoder instance.
// Assumes one clock, mclk, and the synchronous active-high reset sys_rst.
module sxd_decoder_assertions (
	input wire logic              mclk,
	input wire logic              sys_rst,
	input wire logic [7:0]        rx_char,
	input wire logic              rx_valid,
	input wire logic              tx_ready,
	input wire sxd_pkg::sxd_cfg_s cfg,
	input wire sxd_pkg::sxd_val_t reading_one,
	input wire sxd_pkg::sxd_val_t reading_two,
	input wire logic [7:0]        tx_char,
	input wire logic              tx_valid,
	input wire logic [7:0]        bus_addr,
	input wire sxd_pkg::sxd_cal_s cal,
	input wire logic              cmd_done,
	input wire logic              busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dck @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	// A stalled reply character must not move, or the logger would lose it.
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
		else $error("reply character changed before it was taken");
	a_done_pulse: assert property (cmd_done |=> !cmd_done)
		else $error("completion pulse longer than one cycle");
	a_done_busy: assert property (cmd_done |-> $past(busy))
		else $error("completion pulse without a preceding execution step");
	a_addr_quiet: assert property (!$stable(bus_addr) |-> busy || $past(busy) || $past(sys_rst))
		else $error("bus address changed outside a command");
	a_cal_quiet: assert property (!$stable(cal) |-> busy || $past(busy) || $past(sys_rst))
		else $error("calibration changed outside a command");
	a_idle_silent: assert property (!busy |-> !tx_valid)
		else $error("reply character offered while idle");
	a_reset_state: assert property ($fell(sys_rst) |-> bus_addr == 8'h30 && !tx_valid && !busy
		&& cal.offset == '0 && cal.offset_unit == {4'h1, 4'h1})
		else $error("wrong state after reset");
	a_gap_after: assert property (tx_valid && tx_ready |=> !tx_valid ##1 !tx_valid)
		else $error("next reply character came too early");
	a_first_addr: assert property ($rose(tx_valid) && $past(cmd_done, 2)
		|-> tx_char == bus_addr)
		else $error("reply does not start with the bus address");

	// Main scenarios: commands executed, characters taken, address moved.
	c_done: cover property (cmd_done);
	c_taken: cover property (tx_valid && tx_ready);
	c_moved: cover property (!$stable(bus_addr) && !sys_rst);
endmodule : sxd_decoder_assertions

bind sxd_decoder sxd_decoder_assertions chk (.mclk(mclk), .sys_rst(sys_rst), .rx_char(rx_char),
	.rx_valid(rx_valid), .tx_ready(tx_ready), .cfg(cfg), .reading_one(reading_one),
	.reading_two(reading_two), .tx_char(tx_char), .tx_valid(tx_valid), .bus_addr(bus_addr),
	.cal(cal), .cmd_done(cmd_done), .busy(busy));

//--- bench/sxd_logger_model.sv
// Data logger model: sends command text and collects reply characters.
// Assumes the bench waits for the reply to finish before the next command.
module sxd_logger_model (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] tx_char,
	input  wire logic       tx_valid,
	input  wire logic       slow,
	output logic [7:0]      rx_char,
	output logic            rx_valid,
	output logic            tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	string      got = "";
	logic [1:0] cnt = 2'h0;

	initial begin
		rx_char = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end

	// Slow mode takes a character only one cycle in four, so stalls are exercised.
	always @(posedge mclk) begin
		cnt <= cnt + 2'h1;
		tx_ready <= !sys_rst && (!slow || cnt == 2'h3);
		if (tx_valid && tx_ready) begin
			got = {got, " "};
			got[got.len() - 1] = tx_char;
		end
	end

	// Frames open with the address and close with '!', one character per cycle.
	task automatic send(input string s);
		foreach (s[i]) begin
			@(posedge mclk);
			rx_char <= s[i];
			rx_valid <= 1'b1;
		end
		@(posedge mclk);
		rx_valid <= 1'b0;
		rx_char <= ~rx_char; // A released line shows no stale character.
	endtask : send
endmodule : sxd_logger_model

//--- bench/tb_top.sv
// Self-checking bench for the extended command decoder.
// Assumes the logger model in sxd_logger_model.sv and the bound checker.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic              mclk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              slow = 1'b0;
	sxd_pkg::sxd_cfg_s cfg = '0;
	sxd_pkg::sxd_val_t reading_one = 24'h0003E8;
	sxd_pkg::sxd_val_t reading_two = 24'h0001F4;
	logic [7:0]        rx_char, tx_char, bus_addr;
	logic              rx_valid, tx_ready, tx_valid, cmd_done, busy;
	sxd_pkg::sxd_cal_s cal;
	int                err_count = 0;
	int                num_checks = 0;
	int                cyc = 0;

	always #50 mclk = ~mclk;

	sxd_logger_model lg (.mclk(mclk), .sys_rst(sys_rst), .tx_char(tx_char), .tx_valid(tx_valid),
		.slow(slow), .rx_char(rx_char), .rx_valid(rx_valid), .tx_ready(tx_ready));

	sxd_decoder uut (.mclk(mclk), .sys_rst(sys_rst), .rx_char(rx_char), .rx_valid(rx_valid),
		.tx_ready(tx_ready), .cfg(cfg), .reading_one(reading_one), .reading_two(reading_two),
		.tx_char(tx_char), .tx_valid(tx_valid), .bus_addr(bus_addr), .cal(cal),
		.cmd_done(cmd_done), .busy(busy));

	// ------------------------------------------------------------------------
	// Checking helpers
	// ------------------------------------------------------------------------
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	// Sends one command, lets it run out, and compares the whole reply text.
	task automatic run(input string cmd, input string exp);
		int n;
		n = 0;
		lg.got = "";
		lg.send(cmd);
		repeat (6) @(posedge mclk);
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		check({23'h0, lg.got == exp}, 24'h000001);
	endtask : run

	// A hang counts as a mismatch and ends the run.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			complete_run();
		end
	end

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		check({16'h0, bus_addr}, 24'h000030);
		check({16'h0, cal.offset_unit}, 24'h000011);
		run("?X?!", "0\r\n");
		run("7X?!", "0\r\n");
		slow <= 1'b1;
		run("0XAD55!", "50011\r\n");
		check({16'h0, bus_addr}, 24'h000035);
		run("5XAD67!", "");
		check({16'h0, bus_addr}, 24'h000035);
		slow <= 1'b0;
		run("0XAI!", "");
		run("5XAI!", "513ACMEINSTLVL100001\r\n");
		run("5XAI2!", "513ACMEINSTLVL100001\r\n");
		run("5XE+1.25!", "50001\r\n");
		check(cal.offset[0], 24'h00007D);
		check({20'h0, cal.offset_unit[0]}, 24'h000001);
		run("5XE!", "50001\r\n");
		check(cal.offset[0], 24'h00007D);
		cfg.dual_variant <= 1'b1;
		cfg.dual_expanded <= 1'b1;
		cfg.active_line <= 1'b1;
		run("5XE-2.5+3!", "50001\r\n");
		check(cal.offset[1], 24'hFFFF06);
		check({20'h0, cal.offset_unit[1]}, 24'h000003);
		run("5XE1+7!", "50001\r\n");
		check(cal.offset[0], 24'h0002BC);
		cfg.dual_expanded <= 1'b0;
		run("5XE+4!", "50001\r\n");
		check(cal.offset[0], 24'h000190);
		cfg.level_units <= 4'h3;
		run("5XS+30!", "50001\r\n");
		check(cal.offset[0], 24'h000960);
		check({20'h0, cal.offset_unit[0]}, 24'h000003);
		run("5XS2+10!", "50001\r\n");
		check(cal.offset[1], 24'h0000FA);
		cfg.density_mode <= 1'b1;
		for (int u = 0; u < 5; u++) begin
			run($sformatf("5XE2+12+%0d!", u), "50001\r\n");
			check({21'h0, cal.separation_unit}, u[23:0]);
		end
		check(cal.separation, 24'h0004B0);
		run("5XS2+1.05+3!", "50001\r\n");
		check(cal.density, 24'h000069);
		check(cal.offset[0], 24'h000960);
		complete_run();
	end
endmodule : tb_top
